// >>> hw/pcsr_lock.sv
// pll lock acquisition timer
module pcsr_lock (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic nrst,
  // control
  input  wire logic run,
  input  wire logic reload,
  input  wire logic ref_tick,
  // status
  output logic      locked
);
  typedef struct packed {
    pcsr_pkg::pcsr_lock_e                 fsm;
    logic [pcsr_pkg::LOCK_CNT_W-1:0]      cnt;
  } pcsr_lk_s;

  pcsr_lk_s st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    case (st_reg.fsm)
      pcsr_pkg::PCSR_LK_OFF: begin
        st_next.cnt = '0;
        // acquisition waits for the first reference edge
        if (run && ref_tick) begin
          st_next.fsm = pcsr_pkg::PCSR_LK_ACQ;
        end
      end
      pcsr_pkg::PCSR_LK_ACQ: begin
        if (st_reg.cnt == pcsr_pkg::LOCK_CNT_W'(pcsr_pkg::LOCK_CYCLES - 1)) begin
          st_next.fsm = pcsr_pkg::PCSR_LK_LOCKED;
        end else begin
          st_next.cnt = st_reg.cnt + 1'b1;
        end
      end
      pcsr_pkg::PCSR_LK_LOCKED: st_next.cnt = '0;
      default: st_next.fsm = pcsr_pkg::PCSR_LK_OFF;
    endcase
    // new settings or stop drop lock
    if (!run || reload) begin
      st_next.fsm = pcsr_pkg::PCSR_LK_OFF;
      st_next.cnt = '0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '{fsm: pcsr_pkg::PCSR_LK_OFF, cnt: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign locked = (st_reg.fsm == pcsr_pkg::PCSR_LK_LOCKED);

  a_lock_delay: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(locked) |-> $past(st_reg.cnt) == pcsr_pkg::LOCK_CNT_W'(pcsr_pkg::LOCK_CYCLES - 1))
    else $error("lock asserted before acquisition time");
  a_lock_stop: assert property (@(posedge clk_sys) disable iff (!nrst)
    !run |=> !locked) else $error("lock held while pll stopped");
endmodule : pcsr_lock

// >>> hw/pcsr_pkg.sv
// pll configuration shadow register constants
package pcsr_pkg;
  localparam int          ADDR_W          = 18;
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_MULT        = 16'hF000;
  localparam logic [15:0] IDX_PRESCALE    = 16'hF001;
  localparam logic [15:0] IDX_SOURCE      = 16'hF002;
  localparam logic [15:0] IDX_RUN         = 16'hF003;
  localparam logic [15:0] IDX_LOCK        = 16'hF004;
  localparam logic [15:0] IDX_CLKOUT      = 16'hF005;
  // field layouts
  localparam int          MULT_W          = 7;
  localparam int          PRESCALE_W      = 2;
  localparam int          CLKOUT_W        = 3;
  localparam int          SOURCE_BIT      = 0;
  localparam int          RUN_BIT         = 0;
  localparam int          LOCK_BIT        = 0;
  // reset values
  localparam logic [6:0]  RST_MULT        = 7'h60;
  localparam logic [1:0]  RST_PRESCALE    = 2'h0;
  localparam logic        RST_SOURCE      = 1'h0;
  localparam logic        RST_RUN         = 1'h0;
  localparam logic [2:0]  RST_CLKOUT      = 3'h0;
  // timing
  localparam int          CLK_MHZ         = 100;
  localparam int          LOCK_TIME_NS    = 10000;
  localparam int          LOCK_CYCLES     = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int          LOCK_CNT_W      = 11;

  typedef enum logic [1:0] {
    PCSR_LK_OFF    = 2'h0,
    PCSR_LK_ACQ    = 2'h1,
    PCSR_LK_LOCKED = 2'h3
  } pcsr_lock_e;

  // prescale code to number of master clock edges per pll reference edge
  function automatic logic [3:0] pcsr_div_ratio(input logic [1:0] code);
    case (code)
      2'h0:    pcsr_div_ratio = 4'h1;
      2'h1:    pcsr_div_ratio = 4'h2;
      2'h2:    pcsr_div_ratio = 4'h4;
      default: pcsr_div_ratio = 4'h8;
    endcase
  endfunction : pcsr_div_ratio
endpackage : pcsr_pkg

// >>> hw/pcsr_prescale.sv
// master clock pin synchroniser and pll input prescaler
module pcsr_prescale (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  // pin and control
  input  wire logic       master_clock_pin,
  input  wire logic       run,
  input  wire logic [1:0] prescale,
  // reference edge to the pll
  output logic            ref_tick
);
  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic       prev;
    logic [3:0] cnt;
    logic       tick;
  } pcsr_pre_s;

  pcsr_pre_s st_reg, st_next;

  always_comb begin
    st_next       = st_reg;
    st_next.sync1 = master_clock_pin;
    st_next.sync2 = st_reg.sync1;
    st_next.prev  = st_reg.sync2;
    st_next.tick  = 1'b0;
    if (!run) begin
      // no acquisition edges while stopped
      st_next.cnt = 4'h0;
    end else if (st_reg.sync2 && !st_reg.prev) begin
      if (st_reg.cnt + 4'h1 >= pcsr_pkg::pcsr_div_ratio(prescale)) begin
        st_next.cnt  = 4'h0;
        st_next.tick = 1'b1;
      end else begin
        st_next.cnt = st_reg.cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ref_tick = st_reg.tick;

  a_ref_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    !run ##1 !run |-> !ref_tick) else $error("reference edge while pll stopped");
  a_div_one: assert property (@(posedge clk_sys) disable iff (!nrst)
    run && prescale == 2'h0 && st_reg.sync2 && !st_reg.prev |=> ref_tick)
    else $error("divide by one missed an edge");
endmodule : pcsr_prescale

// >>> hw/pcsr_top.sv
// pll configuration shadow registers with avalon-mm slave
//
// The Avalon-MM slave port is this design's own decision.
module pcsr_top (
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  // avalon-mm slave
  input  wire logic [pcsr_pkg::ADDR_W-1:0]   address,
  input  wire logic                          read,
  input  wire logic                          write,
  input  wire logic [31:0]                   writedata,
  input  wire logic [3:0]                    byteenable,
  output logic      [31:0]                   readdata,
  output logic                               waitrequest,
  // master clock pin
  input  wire logic                          master_clock_pin,
  // active clock settings
  output logic      [pcsr_pkg::MULT_W-1:0]   feedback_multiplier,
  output logic      [pcsr_pkg::PRESCALE_W-1:0] active_prescale,
  output logic                               clock_source_bit,
  output logic      [pcsr_pkg::CLKOUT_W-1:0] active_clkout_cfg,
  // pll and clock tree control
  output logic                               pll_ref_tick,
  output logic                               pll_output_en,
  output logic                               pll_locked,
  output logic                               pll_clock_gen_run
);
  typedef struct packed {
    logic [pcsr_pkg::MULT_W-1:0]     pend_mult;
    logic [pcsr_pkg::PRESCALE_W-1:0] pend_pre;
    logic                            pend_src;
    logic [pcsr_pkg::CLKOUT_W-1:0]   pend_clkout;
    logic                            run;
    logic [pcsr_pkg::MULT_W-1:0]     act_mult;
    logic [pcsr_pkg::PRESCALE_W-1:0] act_pre;
    logic                            act_src;
    logic [pcsr_pkg::CLKOUT_W-1:0]   act_clkout;
    logic                            ack;
    logic [31:0]                     rdata;
  } pcsr_state_s;

  pcsr_state_s st_reg, st_next;
  logic        locked;
  logic        ref_tick;
  logic        req;
  logic        aligned;
  logic [15:0] idx;
  logic        wr_take;
  logic        lo_en;
  logic        load;

  // one wait state on every access so read data can come from a flop
  assign req     = read | write;
  assign aligned = (address[1:0] == 2'h0);
  assign idx     = 16'(address[pcsr_pkg::ADDR_W-1:2]);
  assign wr_take = write & st_reg.ack;
  assign lo_en   = byteenable[0];

  // enable rising edge, caught on the write itself
  assign load = wr_take && aligned && lo_en && idx == pcsr_pkg::IDX_RUN &&
                !st_reg.run && writedata[pcsr_pkg::RUN_BIT];

  always_comb begin
    st_next       = st_reg;
    st_next.ack   = req & ~st_reg.ack;
    st_next.rdata = 32'h0;
    if (read && !st_reg.ack && aligned) begin
      // reserved and unmapped bits read zero
      case (idx)
        pcsr_pkg::IDX_MULT:     st_next.rdata[pcsr_pkg::MULT_W-1:0] = st_reg.pend_mult;
        pcsr_pkg::IDX_PRESCALE: st_next.rdata[pcsr_pkg::PRESCALE_W-1:0] = st_reg.pend_pre;
        pcsr_pkg::IDX_SOURCE:   st_next.rdata[pcsr_pkg::SOURCE_BIT] = st_reg.pend_src;
        pcsr_pkg::IDX_RUN:      st_next.rdata[pcsr_pkg::RUN_BIT] = st_reg.run;
        pcsr_pkg::IDX_LOCK:     st_next.rdata[pcsr_pkg::LOCK_BIT] = locked;
        pcsr_pkg::IDX_CLKOUT:   st_next.rdata[pcsr_pkg::CLKOUT_W-1:0] = st_reg.pend_clkout;
        default:                st_next.rdata = 32'h0;
      endcase
    end
    if (wr_take && aligned && lo_en) begin
      // setting writes land in shadow storage only; the enable write goes straight to run
      case (idx)
        pcsr_pkg::IDX_MULT:     st_next.pend_mult = writedata[pcsr_pkg::MULT_W-1:0];
        pcsr_pkg::IDX_PRESCALE: st_next.pend_pre = writedata[pcsr_pkg::PRESCALE_W-1:0];
        pcsr_pkg::IDX_SOURCE:   st_next.pend_src = writedata[pcsr_pkg::SOURCE_BIT];
        pcsr_pkg::IDX_RUN:      st_next.run = writedata[pcsr_pkg::RUN_BIT];
        pcsr_pkg::IDX_CLKOUT:   st_next.pend_clkout = writedata[pcsr_pkg::CLKOUT_W-1:0];
        default:                st_next.run = st_reg.run;
      endcase
    end
    if (load) begin
      st_next.act_mult   = st_reg.pend_mult;
      st_next.act_pre    = st_reg.pend_pre;
      st_next.act_src    = st_reg.pend_src;
      st_next.act_clkout = st_reg.pend_clkout;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '{pend_mult:   pcsr_pkg::RST_MULT,
                  pend_pre:    pcsr_pkg::RST_PRESCALE,
                  pend_src:    pcsr_pkg::RST_SOURCE,
                  pend_clkout: pcsr_pkg::RST_CLKOUT,
                  run:         pcsr_pkg::RST_RUN,
                  act_mult:    pcsr_pkg::RST_MULT,
                  act_pre:     pcsr_pkg::RST_PRESCALE,
                  act_src:     pcsr_pkg::RST_SOURCE,
                  act_clkout:  pcsr_pkg::RST_CLKOUT,
                  ack:         1'b0,
                  rdata:       32'h0};
    end else begin
      st_reg <= st_next;
    end
  end

  // prescaler sees the active code, never the pending one
  pcsr_prescale u_prescale (
    .clk_sys          (clk_sys),
    .nrst             (nrst),
    .master_clock_pin (master_clock_pin),
    .run              (st_reg.run),
    .prescale         (st_reg.act_pre),
    .ref_tick         (ref_tick)
  );

  // a reload restarts acquisition with the new divider and multiplier
  pcsr_lock u_lock (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .run      (st_reg.run),
    .reload   (load),
    .ref_tick (ref_tick),
    .locked   (locked)
  );

  assign readdata            = st_reg.rdata;
  assign waitrequest         = req & ~st_reg.ack;
  assign feedback_multiplier = st_reg.act_mult;
  assign active_prescale     = st_reg.act_pre;
  assign clock_source_bit    = st_reg.act_src;
  assign active_clkout_cfg   = st_reg.act_clkout;
  assign pll_ref_tick        = ref_tick;
  assign pll_output_en       = st_reg.run;
  assign pll_locked          = locked;
  // pin-sourced generators run regardless; pll-sourced ones idle when stopped
  assign pll_clock_gen_run   = !st_reg.act_src || st_reg.run;

  a_mult_reset: assert property (@(posedge clk_sys)
    $rose(nrst) |-> feedback_multiplier == 7'h60 && st_reg.pend_mult == 7'h60)
    else $error("multiplier not ninety-six after reset");
  a_load_pending: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(st_reg.run) |-> feedback_multiplier == $past(st_reg.pend_mult) &&
      active_prescale == $past(st_reg.pend_pre) &&
      clock_source_bit == $past(st_reg.pend_src) &&
      active_clkout_cfg == $past(st_reg.pend_clkout))
    else $error("pending settings not loaded on enable rise");
  a_hold_active: assert property (@(posedge clk_sys) disable iff (!nrst)
    !$rose(st_reg.run) |-> $stable({feedback_multiplier, active_prescale, clock_source_bit,
      active_clkout_cfg})) else $error("active setting moved without enable rise");
  a_stop_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    !pll_output_en && clock_source_bit |-> !pll_clock_gen_run)
    else $error("pll clock circuits running while stopped");
  a_resv_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
    read && !waitrequest |-> readdata[31:8] == 24'h0)
    else $error("reserved read bits not zero");
  a_one_wait: assert property (@(posedge clk_sys) disable iff (!nrst)
    req && waitrequest |=> !waitrequest) else $error("access stalled beyond one cycle");

  // bus timing: one wait state, data only in the answer cycle
  a_first_wait: assert property (@(posedge clk_sys) disable iff (!nrst)
    req && !$past(req) |-> waitrequest)
    else $error("new access not stalled for a cycle");

  a_ack_single: assert property (@(posedge clk_sys) disable iff (!nrst)
    st_reg.ack |=> !st_reg.ack)
    else $error("acknowledge held for two cycles");

  a_idle_nowait: assert property (@(posedge clk_sys) disable iff (!nrst)
    !req |-> !waitrequest)
    else $error("waitrequest raised with no access");

  a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(read && !waitrequest) |-> readdata == 32'h0)
    else $error("read data outside the answer cycle");

  a_wr_no_rdata: assert property (@(posedge clk_sys) disable iff (!nrst)
    write |-> readdata == 32'h0)
    else $error("read data during a write");

  // read back: shadow, enable and lock values in the low bits, zero above them
  a_rd_mult: assert property (@(posedge clk_sys) disable iff (!nrst)
    read && !waitrequest && aligned && idx == pcsr_pkg::IDX_MULT |->
      readdata == {25'h0, st_reg.pend_mult})
    else $error("multiplier read back wrong");

  a_rd_prescale: assert property (@(posedge clk_sys) disable iff (!nrst)
    read && !waitrequest && aligned && idx == pcsr_pkg::IDX_PRESCALE |->
      readdata == {30'h0, st_reg.pend_pre})
    else $error("prescale read back wrong");

  a_rd_source: assert property (@(posedge clk_sys) disable iff (!nrst)
    read && !waitrequest && aligned && idx == pcsr_pkg::IDX_SOURCE |->
      readdata == {31'h0, st_reg.pend_src})
    else $error("source select read back wrong");

  a_rd_run: assert property (@(posedge clk_sys) disable iff (!nrst)
    read && !waitrequest && aligned && idx == pcsr_pkg::IDX_RUN |->
      readdata == {31'h0, st_reg.run})
    else $error("enable read back wrong");

  a_rd_lock: assert property (@(posedge clk_sys) disable iff (!nrst)
    read && !waitrequest && aligned && idx == pcsr_pkg::IDX_LOCK |->
      readdata == {31'h0, $past(locked)})
    else $error("lock flag read back wrong");

  a_rd_clkout: assert property (@(posedge clk_sys) disable iff (!nrst)
    read && !waitrequest && aligned && idx == pcsr_pkg::IDX_CLKOUT |->
      readdata == {29'h0, st_reg.pend_clkout})
    else $error("clock-out config read back wrong");

  a_rd_unaligned: assert property (@(posedge clk_sys) disable iff (!nrst)
    read && !waitrequest && !aligned |-> readdata == 32'h0)
    else $error("unaligned read not zero");

  a_rd_unmapped: assert property (@(posedge clk_sys) disable iff (!nrst)
    read && !waitrequest && (idx < pcsr_pkg::IDX_MULT || idx > pcsr_pkg::IDX_CLKOUT) |->
      readdata == 32'h0)
    else $error("unmapped read not zero");

  // setting writes land in shadow storage and the enable write in run, masked to the field
  a_wr_mult: assert property (@(posedge clk_sys) disable iff (!nrst)
    write && !waitrequest && aligned && lo_en && idx == pcsr_pkg::IDX_MULT |=>
      {25'h0, st_reg.pend_mult} == ($past(writedata) & 32'h7F))
    else $error("multiplier write not stored");

  a_wr_prescale: assert property (@(posedge clk_sys) disable iff (!nrst)
    write && !waitrequest && aligned && lo_en && idx == pcsr_pkg::IDX_PRESCALE |=>
      {30'h0, st_reg.pend_pre} == ($past(writedata) & 32'h3))
    else $error("prescale write not stored");

  a_wr_source: assert property (@(posedge clk_sys) disable iff (!nrst)
    write && !waitrequest && aligned && lo_en && idx == pcsr_pkg::IDX_SOURCE |=>
      {31'h0, st_reg.pend_src} == ($past(writedata) & 32'h1))
    else $error("source select write not stored");

  a_wr_clkout: assert property (@(posedge clk_sys) disable iff (!nrst)
    write && !waitrequest && aligned && lo_en && idx == pcsr_pkg::IDX_CLKOUT |=>
      {29'h0, st_reg.pend_clkout} == ($past(writedata) & 32'h7))
    else $error("clock-out config write not stored");

  a_wr_run: assert property (@(posedge clk_sys) disable iff (!nrst)
    write && !waitrequest && aligned && lo_en && idx == pcsr_pkg::IDX_RUN |=>
      {31'h0, st_reg.run} == ($past(writedata) & 32'h1))
    else $error("enable write not stored");

  a_wr_ignored: assert property (@(posedge clk_sys) disable iff (!nrst)
    write && !waitrequest && (!aligned || !lo_en) |=>
      $stable({st_reg.pend_mult, st_reg.pend_pre, st_reg.pend_src, st_reg.pend_clkout,
               st_reg.run}))
    else $error("ignored write changed a register");

  a_pend_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    !(write && !waitrequest) |=>
      $stable({st_reg.pend_mult, st_reg.pend_pre, st_reg.pend_src, st_reg.pend_clkout,
               st_reg.run}))
    else $error("shadow register moved without a write");

  // enable edge loads everything at once and restarts acquisition
  a_load_cause: assert property (@(posedge clk_sys) disable iff (!nrst)
    $rose(pll_output_en) |-> $past(load))
    else $error("enable rose without a load");

  a_load_sets: assert property (@(posedge clk_sys) disable iff (!nrst)
    load |=> pll_output_en)
    else $error("load did not set the enable");

  a_load_clkout: assert property (@(posedge clk_sys) disable iff (!nrst)
    load |=> active_clkout_cfg == $past(st_reg.pend_clkout))
    else $error("clock-out config not loaded");

  a_load_unlock: assert property (@(posedge clk_sys) disable iff (!nrst)
    load |=> !pll_locked)
    else $error("lock kept across new settings");

  // a stopped pll neither acquires nor sends reference edges
  a_stop_unlock: assert property (@(posedge clk_sys) disable iff (!nrst)
    !pll_output_en |=> !pll_locked)
    else $error("lock flag set while stopped");

  a_lock_run: assert property (@(posedge clk_sys) disable iff (!nrst)
    pll_locked |-> $past(pll_output_en))
    else $error("lock flag without enable");

  a_tick_run: assert property (@(posedge clk_sys) disable iff (!nrst)
    pll_ref_tick |-> $past(pll_output_en))
    else $error("reference edge without enable");

  a_tick_single: assert property (@(posedge clk_sys) disable iff (!nrst)
    pll_ref_tick |=> !pll_ref_tick)
    else $error("reference edge wider than one cycle");

  a_src_pin: assert property (@(posedge clk_sys) disable iff (!nrst)
    !clock_source_bit |-> pll_clock_gen_run)
    else $error("pin-sourced generators stopped");

  a_pll_gen: assert property (@(posedge clk_sys) disable iff (!nrst)
    pll_output_en && clock_source_bit |-> pll_clock_gen_run)
    else $error("pll-sourced generators idle while running");

  // state right after reset release
  a_src_reset: assert property (@(posedge clk_sys)
    $rose(nrst) |-> !clock_source_bit && !pll_output_en && pll_clock_gen_run)
    else $error("clock source state wrong after reset");

  a_lock_reset: assert property (@(posedge clk_sys)
    $rose(nrst) |-> !pll_locked && !pll_ref_tick && readdata == 32'h0)
    else $error("lock or read data set after reset");
endmodule : pcsr_top

// >>> tb/pcsr_top_test.sv
// self-checking bench for the pll configuration shadow registers
module pcsr_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys, nrst, read, write, master_clock_pin;
  logic [17:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0]  byteenable;
  logic        waitrequest, clock_source_bit, pll_ref_tick;
  logic        pll_output_en, pll_locked, pll_clock_gen_run;
  logic [6:0]  feedback_multiplier;
  logic [1:0]  active_prescale;
  logic [2:0]  active_clkout_cfg;
  int          num_errors, samples_checked, ticks;
  logic [31:0] rst_val [6] = '{32'h60, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};

  pcsr_top uut (.clk_sys(clk_sys), .nrst(nrst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .master_clock_pin(master_clock_pin),
    .feedback_multiplier(feedback_multiplier), .active_prescale(active_prescale),
    .clock_source_bit(clock_source_bit), .active_clkout_cfg(active_clkout_cfg),
    .pll_ref_tick(pll_ref_tick), .pll_output_en(pll_output_en), .pll_locked(pll_locked),
    .pll_clock_gen_run(pll_clock_gen_run));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) if (pll_ref_tick === 1'b1) ticks++;

  function automatic logic [17:0] ra(input logic [15:0] idx);
    return {idx, 2'h0};
  endfunction : ra

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // request held until waitrequest low at a rising edge, released at that edge
  task automatic bus_op(input logic wr, input logic [17:0] a, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    address    <= a;
    writedata  <= d;
    byteenable <= be;
    read       <= !wr;
    write      <= wr;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) check(1'b1, 1'b0);
    q = readdata;
    read  <= 1'b0;
    write <= 1'b0;
    // later checks see settled outputs, not the launching edge
    @(negedge clk_sys);
  endtask : bus_op

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus_op(1'b1, ra(idx), d, 4'hF, q);
  endtask : wr

  task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_op(1'b0, a, 32'h0, 4'hF, q);
    check(q, exp);
  endtask : rd_chk

  // pin period of eight system cycles, slow enough for the synchroniser
  task automatic pin_edges(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_sys);
      master_clock_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      master_clock_pin <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
  endtask : pin_edges

  task automatic tally_and_finish;
    $display("errors %0d, comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  // tests need a few thousand cycles; twenty thousand means a hang
  initial begin
    #200us;
    num_errors++;
    tally_and_finish;
  end

  initial begin
    nrst = 1'b0; read = 1'b0; write = 1'b0; address = '0; writedata = '0;
    byteenable = '0; master_clock_pin = 1'b0; num_errors = 0; samples_checked = 0; ticks = 0;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) rd_chk(ra(16'hF000 + 16'(i)), rst_val[i]);
    check(32'(feedback_multiplier), 32'h60);
    check(32'(pll_clock_gen_run), 32'h1);
    // all-ones writes: reserved bits drop, active side untouched
    wr(16'hF000, 32'hFFFF_FFFF);
    wr(16'hF001, 32'hFFFF_FFFF);
    wr(16'hF002, 32'hFFFF_FFFF);
    wr(16'hF005, 32'hFFFF_FFFF);
    rd_chk(ra(16'hF000), 32'h7F);
    rd_chk(ra(16'hF001), 32'h3);
    rd_chk(ra(16'hF002), 32'h1);
    rd_chk(ra(16'hF005), 32'h7);
    check({active_clkout_cfg, clock_source_bit, active_prescale, feedback_multiplier},
          {3'h0, 1'h0, 2'h0, 7'h60});
    rd_chk(18'h00400, 32'h0);
    rd_chk(ra(16'hF000) + 18'h1, 32'h0);
    begin
      logic [31:0] q;
      bus_op(1'b1, ra(16'hF000), 32'h22, 4'h0, q);
    end
    rd_chk(ra(16'hF000), 32'h7F);
    // disabled: no reference edges, no lock, no pll output
    pin_edges(8);
    check(32'(ticks), 32'h0);
    check({pll_locked, pll_output_en}, 2'h0);
    // each prescale code, applied through a fresh enable edge
    for (int c = 0; c < 4; c++) begin
      wr(16'hF003, 32'h0);
      wr(16'hF001, 32'(c));
      wr(16'hF003, 32'h1);
      check({active_clkout_cfg, clock_source_bit, active_prescale, feedback_multiplier},
            {3'h7, 1'h1, 2'(c), 7'h7F});
      check({pll_output_en, pll_clock_gen_run}, 2'h3);
      ticks = 0;
      pin_edges(16);
      check(32'(ticks), 32'(16 >> c));
    end
    check(32'(pll_locked), 32'h0);
    pin_edges(150);
    check(32'(pll_locked), 32'h1);
    rd_chk(ra(16'hF004), 32'h1);
    // a second write of one is not a rising edge
    wr(16'hF000, 32'h11);
    wr(16'hF003, 32'h1);
    check(32'(feedback_multiplier), 32'h7F);
    wr(16'hF003, 32'h0);
    repeat (2) @(posedge clk_sys);
    check({pll_locked, pll_output_en, pll_clock_gen_run}, 3'h0);
    rd_chk(ra(16'hF004), 32'h0);
    check(32'(feedback_multiplier), 32'h7F);
    wr(16'hF002, 32'h0);
    wr(16'hF003, 32'h1);
    check({clock_source_bit, feedback_multiplier}, {1'h0, 7'h11});
    wr(16'hF003, 32'h0);
    check(32'(pll_clock_gen_run), 32'h1);
    rd_chk(ra(16'hF003), 32'h0);
    tally_and_finish;
  end
endmodule : pcsr_top_test
